// ===== hw/pfc_pkg.sv
// Constants of the synthesizer frequency-control block: register map,
// field layout, reset values and loop-model tuning.
// Assumes a 250 MHz bus clock and a 32-bit AXI4-Lite register port.
`default_nettype none
package pfc_pkg;

  // Bus clock
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Register byte offsets
  localparam logic [7:0] ADDR_SYNTH      = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
  localparam logic [7:0] ADDR_REF_CTRL   = 8'h0C;

  // Synthesizer control register layout and reset value
  localparam logic [15:0] SYNTH_RESET  = 16'h3F00;
  localparam int unsigned PRESCALE_BIT = 15;
  localparam int unsigned OUTDIV_BIT   = 14;
  localparam int unsigned MOD_LSB      = 8;
  localparam int unsigned MOD_W        = 6;
  localparam int unsigned LOCK_BIT     = 3;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_LOCK_BIT = 0;
  localparam int unsigned IRQ_LOSS_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // Reference control register: bit 0 enables the reference pre-divider
  localparam int unsigned REF_DIV_BIT   = 0;
  localparam logic        REF_DIV_RESET = 1'b0;

  // Reference pre-divider for megahertz references
  localparam int unsigned REF_PREDIV    = 128;
  localparam int unsigned REF_PREDIV_W  = 7;

  // Feedback chain: fixed prescaler, prescaler tap, post divider
  localparam logic [3:0] FB_PRE_LAST   = 4'h3;
  localparam logic [3:0] FB_TAP_LAST   = 4'hF;
  localparam logic [1:0] FB_POST_LAST  = 2'h3;

  // Oscillator model
  localparam int unsigned NCO_W         = 24;
  localparam logic [23:0] NCO_FW_RESET  = 24'h010000;
  localparam logic [23:0] NCO_FW_STEP   = 24'h000100;
  localparam logic [23:0] NCO_FW_MAX    = 24'h7FFFFF;
  localparam int unsigned LOCK_PERIODS  = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pfc_pkg
`default_nettype wire

// ===== hw/pfc_fb_if.sv
// Carrier between the loop controller and the feedback divider.
// Assumes both ends run on the same bus clock.
`timescale 1ns/100ps
`default_nettype none
interface pfc_fb_if;
  logic                    prescale_tap;
  logic [pfc_pkg::MOD_W-1:0] loop_modulus;
  logic                    vco_tick;
  logic                    restart;
  logic                    fb_tick;

  modport ctl (output prescale_tap, output loop_modulus, output vco_tick,
               output restart, input fb_tick);
  modport div (input prescale_tap, input loop_modulus, input vco_tick,
               input restart, output fb_tick);
endinterface : pfc_fb_if
`default_nettype wire

// ===== hw/pfc_fb_divider.sv
// Feedback divider of the synthesizer loop: prescaler with selectable tap,
// modulo down counter and fixed post divider, all stepped by oscillator ticks.
// Assumes vco_tick is a one-cycle pulse at most once per clock.
`timescale 1ns/100ps
`default_nettype none
module pfc_fb_divider (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Loop side
  pfc_fb_if.div     fb
);

  logic [3:0]                pre_q;
  logic [pfc_pkg::MOD_W-1:0] mod_q;
  logic [1:0]                post_q;
  logic                      fb_tick_q;
  logic                      pre_wrap;
  logic                      mod_wrap;

  // Prescaler tap: /4 or /16 of the oscillator
  assign pre_wrap = fb.vco_tick &&
                    (pre_q == (fb.prescale_tap ? pkg_tap() : pkg_pre()));
  assign mod_wrap = pre_wrap && (mod_q == '0);
  function automatic logic [3:0] pkg_tap();
    return pfc_pkg::FB_TAP_LAST;
  endfunction : pkg_tap
  function automatic logic [3:0] pkg_pre();
    return pfc_pkg::FB_PRE_LAST;
  endfunction : pkg_pre

  // Prescaler counter
  always_ff @(posedge aclk) begin
    if (!aresetn || fb.restart) begin
      pre_q <= '0;
    end else if (pre_wrap) begin
      pre_q <= '0;
    end else if (fb.vco_tick) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Modulo down counter, divides by modulus plus one
  always_ff @(posedge aclk) begin
    if (!aresetn || fb.restart) begin
      mod_q <= fb.loop_modulus;
    end else if (mod_wrap) begin
      mod_q <= fb.loop_modulus;
    end else if (pre_wrap) begin
      mod_q <= mod_q - 6'h01;
    end
  end

  // Fixed post divider and output pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || fb.restart) begin
      post_q    <= '0;
      fb_tick_q <= 1'b0;
    end else begin
      fb_tick_q <= mod_wrap && (post_q == pfc_pkg::FB_POST_LAST);
      if (mod_wrap) begin
        post_q <= post_q + 2'h1;
      end
    end
  end

  assign fb.fb_tick = fb_tick_q;

endmodule : pfc_fb_divider
`default_nettype wire

// ===== hw/pfc_top.sv
// Synthesizer frequency control: control register over AXI4-Lite, a
// digital loop model (oscillator, feedback divider, lock detector), the
// output divide-by-four or divide-by-two stage, bypass strap and held system reset.
// Assumes reference_input and clock_source_strap are synchronous to aclk.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pfc_top #(
  parameter int unsigned LOCK_PERIODS = pfc_pkg::LOCK_PERIODS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Reference and strap
  input  wire logic        reference_input,
  input  wire logic        clock_source_strap,
  // Clock and reset outputs
  output logic             sys_clk,
  output logic             sys_reset_n,
  output logic             pll_lock_flag,
  // Interrupt
  output logic             irq
);

  // Register state
  logic [15:0]             synth_frequency_control_q;
  logic [pfc_pkg::IRQ_W-1:0] irq_status_q;
  logic [pfc_pkg::IRQ_W-1:0] irq_mask_q;
  logic                    ref_div_en_q;
  logic                    strap_q;

  // Bus state
  logic                    aw_held_q;
  logic                    w_held_q;
  logic [7:0]              awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    awready_q;
  logic                    wready_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    arready_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;

  // Loop state
  logic                    ref_prev_q;
  logic [pfc_pkg::REF_PREDIV_W-1:0] ref_div_q;
  logic [pfc_pkg::NCO_W-1:0] nco_acc_q;
  logic [pfc_pkg::NCO_W-1:0] fw_q;
  logic                    vco_tick_q;
  logic [1:0]              fb_cnt_q;
  logic [3:0]              good_q;
  logic                    lock_q;
  logic                    lock_prev_q;
  logic                    out_phase_q;
  logic                    sys_clk_q;
  logic                    sys_reset_n_q;
  logic                    irq_q;

  // Combinational helpers
  logic                    wr_fire;
  logic                    wr_hit;
  logic                    relock;
  logic [15:0]             synth_d;
  logic                    ref_edge;
  logic                    ref_tick;
  logic [pfc_pkg::NCO_W:0] nco_sum;
  logic                    lock_rise;
  logic                    lock_fall;
  logic [pfc_pkg::IRQ_W-1:0] irq_set;

  pfc_fb_if fb ();

  // Feedback divider in the loop
  pfc_fb_divider u_fb_divider (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (fb.div)
  );

  // Only the upper byte steers the loop
  assign fb.prescale_tap = synth_frequency_control_q[pfc_pkg::PRESCALE_BIT];
  assign fb.loop_modulus = relock ? synth_d[pfc_pkg::MOD_LSB +: pfc_pkg::MOD_W] :
                           synth_frequency_control_q[pfc_pkg::MOD_LSB +: pfc_pkg::MOD_W];
  assign fb.vco_tick     = vco_tick_q;
  assign fb.restart      = relock;

  // ---- Register bus ----

  // Write fires once address and data are both held
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit  = (awaddr_q == pfc_pkg::ADDR_SYNTH) ||
                   (awaddr_q == pfc_pkg::ADDR_IRQ_STATUS) ||
                   (awaddr_q == pfc_pkg::ADDR_IRQ_MASK) ||
                   (awaddr_q == pfc_pkg::ADDR_REF_CTRL);

  // New control value; the low byte has no writable bits
  always_comb begin
    synth_d = synth_frequency_control_q;
    if (wstrb_q[1]) begin
      synth_d[15:8] = wdata_q[15:8];
    end
  end

  // Loop settings changed by this write
  assign relock = wr_fire && (awaddr_q == pfc_pkg::ADDR_SYNTH) &&
                  (synth_d[15] != synth_frequency_control_q[15] ||
                   synth_d[13:8] != synth_frequency_control_q[13:8]);

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      awready_q <= 1'b0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
      awready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (!aw_held_q) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      wready_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
      wready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      w_held_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (!w_held_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pfc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? pfc_pkg::RESP_OKAY : pfc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Synthesizer control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synth_frequency_control_q <= pfc_pkg::SYNTH_RESET;
    end else if (wr_fire && awaddr_q == pfc_pkg::ADDR_SYNTH) begin
      synth_frequency_control_q <= synth_d;
    end
  end

  // Mask and reference control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q   <= pfc_pkg::IRQ_MASK_RESET;
      ref_div_en_q <= pfc_pkg::REF_DIV_RESET;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == pfc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_q[pfc_pkg::IRQ_W-1:0];
      end
      if (awaddr_q == pfc_pkg::ADDR_REF_CTRL) begin
        ref_div_en_q <= wdata_q[pfc_pkg::REF_DIV_BIT];
      end
    end
  end

  // Read address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= pfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= pfc_pkg::RESP_OKAY;
      rdata_q   <= '0;
      unique case ({s_axi_araddr[7:2], 2'h0})
        pfc_pkg::ADDR_SYNTH: begin
          rdata_q[15:8]             <= synth_frequency_control_q[15:8];
          rdata_q[pfc_pkg::LOCK_BIT] <= lock_q;
        end
        pfc_pkg::ADDR_IRQ_STATUS: rdata_q[pfc_pkg::IRQ_W-1:0] <= irq_status_q;
        pfc_pkg::ADDR_IRQ_MASK:   rdata_q[pfc_pkg::IRQ_W-1:0] <= irq_mask_q;
        pfc_pkg::ADDR_REF_CTRL:   rdata_q[pfc_pkg::REF_DIV_BIT] <= ref_div_en_q;
        default:                  rresp_q <= pfc_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // ---- Clock source strap ----

  // Strap is caught while reset is asserted and frozen afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= clock_source_strap;
    end
  end

  // ---- Reference path ----

  // Rising edge of the reference, optionally divided by 128
  assign ref_edge = reference_input && !ref_prev_q;
  assign ref_tick = ref_edge &&
                    (!ref_div_en_q || ref_div_q == '1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_q <= reference_input;  // No false edge at release
      ref_div_q  <= '0;
    end else begin
      ref_prev_q <= reference_input;
      if (ref_edge && ref_div_en_q) begin
        ref_div_q <= ref_div_q + 7'h01;
      end
    end
  end

  // ---- Oscillator model ----

  // Phase accumulator; carry out is one oscillator period
  assign nco_sum = {1'b0, nco_acc_q} + {1'b0, fw_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nco_acc_q  <= '0;
      vco_tick_q <= 1'b0;
    end else begin
      nco_acc_q  <= nco_sum[pfc_pkg::NCO_W-1:0];
      vco_tick_q <= nco_sum[pfc_pkg::NCO_W];
    end
  end

  // Feedback pulses seen in the current reference period
  always_ff @(posedge aclk) begin
    if (!aresetn || relock) begin
      fb_cnt_q <= '0;
    end else if (ref_tick) begin
      fb_cnt_q <= fb.fb_tick ? 2'h1 : 2'h0;
    end else if (fb.fb_tick && fb_cnt_q != 2'h3) begin
      fb_cnt_q <= fb_cnt_q + 2'h1;
    end
  end

  // Frequency word steered so one feedback pulse matches each reference
  // period; oscillator runs at 16 (Y+1) 4^W times the loop reference.
  // A raise of the loop settings lets the word ramp and may overshoot.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fw_q <= pfc_pkg::NCO_FW_RESET;
    end else if (ref_tick) begin
      if (fb_cnt_q == 2'h0 && fw_q < pfc_pkg::NCO_FW_MAX) begin
        fw_q <= fw_q + pfc_pkg::NCO_FW_STEP;
      end else if (fb_cnt_q > 2'h1 && fw_q > pfc_pkg::NCO_FW_STEP) begin
        fw_q <= fw_q - pfc_pkg::NCO_FW_STEP;
      end
    end
  end

  // Lock detector: consecutive matched reference periods
  always_ff @(posedge aclk) begin
    if (!aresetn || relock) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (ref_tick) begin
      if (fb_cnt_q == 2'h1) begin
        if (good_q != 4'hF) begin
          good_q <= good_q + 4'h1;
        end
        if (32'(good_q) + 1 >= LOCK_PERIODS) begin
          lock_q <= 1'b1;
        end
      end else begin
        good_q <= '0;
        lock_q <= 1'b0;
      end
    end
  end

  // ---- System clock and reset ----

  // Output stage outside the loop: oscillator /4, or /2 with divide select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_phase_q <= 1'b0;
      sys_clk_q   <= 1'b0;
    end else if (!strap_q) begin
      sys_clk_q <= reference_input;
    end else if (vco_tick_q) begin
      out_phase_q <= !out_phase_q;
      if (synth_frequency_control_q[pfc_pkg::OUTDIV_BIT] || out_phase_q) begin
        sys_clk_q <= !sys_clk_q;
      end
    end
  end

  // System reset held until first lock; bypass releases at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_n_q <= 1'b0;
    end else if (!strap_q || lock_q) begin
      sys_reset_n_q <= 1'b1;
    end
  end

  // ---- Interrupts ----

  // Lock gained and lock lost events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
    end
  end

  assign lock_rise = lock_q && !lock_prev_q && strap_q;
  assign lock_fall = !lock_q && lock_prev_q && strap_q;
  always_comb begin
    irq_set                        = '0;
    irq_set[pfc_pkg::IRQ_LOCK_BIT] = lock_rise;
    irq_set[pfc_pkg::IRQ_LOSS_BIT] = lock_fall;
  end

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
    end else if (wr_fire && wstrb_q[0] && awaddr_q == pfc_pkg::ADDR_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~wdata_q[pfc_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // Level interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign sys_clk       = sys_clk_q;
  assign sys_reset_n   = sys_reset_n_q;
  assign pll_lock_flag = lock_q;
  assign irq           = irq_q;

endmodule : pfc_top
`default_nettype wire

// ===== testbench/pfc_ref_model.sv
// Reference source model standing at the loop input of the block.
// Assumes half_cycles is at least one and is set by the bench.
`timescale 1ns/100ps
`default_nettype none
module pfc_ref_model (
  // Clock
  input  wire logic        aclk,
  // Period control, half period in bus clocks
  input  wire logic [11:0] half_cycles,
  // Reference out
  output logic             reference_input
);
  logic [11:0] cnt_q;

  initial cnt_q = 12'h000;
  initial reference_input = 1'b0;

  // Free-running square wave, slow or megahertz range
  always @(posedge aclk) begin
    if (cnt_q >= half_cycles - 12'h001) begin
      cnt_q <= 12'h000;
      reference_input <= ~reference_input;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
endmodule : pfc_ref_model
`default_nettype wire

// ===== testbench/pfc_checker.sv
// Assertion checker for the frequency-control block, bound to its top.
// Assumes one bus clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pfc_checker #(
  parameter int unsigned LOCK_PERIODS = 8
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Clocking
  input wire logic        reference_input,
  input wire logic        clock_source_strap,
  input wire logic        sys_clk,
  input wire logic        sys_reset_n,
  input wire logic        pll_lock_flag
);
  logic       strap_q;
  logic       bv_q;
  logic [7:0] aw_q;
  logic [3:0] ws_q;
  logic [6:0] wd_q;
  logic [6:0] set_q;
  logic       ctl_wr;
  logic       new_loop;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Strap kept from reset; last write captured
  always_ff @(posedge aclk) begin
    bv_q <= s_axi_bvalid;
    if (!aresetn) strap_q <= clock_source_strap;
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb;
    if (s_axi_wvalid && s_axi_wready) wd_q <= {s_axi_wdata[15], s_axi_wdata[13:8]};
  end

  // Shadow of prescale and modulus as last written
  always_ff @(posedge aclk) begin
    if (!aresetn) set_q <= 7'h3F;
    else if (s_axi_bvalid && !bv_q && ctl_wr) set_q <= wd_q;
  end

  assign ctl_wr   = (aw_q == pfc_pkg::ADDR_SYNTH) && ws_q[1];
  assign new_loop = wd_q != set_q;

  AST_RST_GATE: assert property ($rose(sys_reset_n) |-> !strap_q || $past(pll_lock_flag))
    else $error("system reset released without lock");
  AST_RST_STAY: assert property (sys_reset_n |=> sys_reset_n)
    else $error("system reset asserted again");
  AST_BYP_RST: assert property (!strap_q |-> ##2 sys_reset_n)
    else $error("bypass left system reset low");
  AST_BYP_CLK: assert property (!strap_q && $past(aresetn) |=> sys_clk == $past(reference_input))
    else $error("bypass clock does not follow reference");
  AST_LOCK_DROP: assert property (s_axi_bvalid && !bv_q && ctl_wr && new_loop |-> !pll_lock_flag)
    else $error("lock kept after new loop setting");
  AST_X_ONLY: assert property (s_axi_bvalid && !bv_q && ctl_wr && !new_loop
    && $past(pll_lock_flag) |-> pll_lock_flag)
    else $error("lock lost on divider-only write");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03
    |=> s_axi_rresp == pfc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");

  // Main scenarios
  cover property ($rose(sys_reset_n) && strap_q);
  cover property (s_axi_bvalid && !bv_q && ctl_wr && new_loop);
  cover property ($rose(pll_lock_flag));
endmodule : pfc_checker
`default_nettype wire

bind pfc_top pfc_checker #(.LOCK_PERIODS(LOCK_PERIODS)) i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .reference_input, .clock_source_strap, .sys_clk, .sys_reset_n,
  .pll_lock_flag
);

// ===== testbench/tb_top.sv
// Testbench of the frequency-control block: bus master tasks, reference
// model and a queue-based response monitor.
// Assumes reference periods of 4096 bus clocks at the loop input.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  int          errors = 0;
  int          tests_run = 0;
  logic [31:0] rnd = 32'h0001_0668;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        strap = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [11:0] half = 12'h800;
  logic        awready, wready, bvalid, arready, rvalid, ref_in, sys_clk, sys_reset_n, lock, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;

  // Bus clock, 4 ns
  always #2 aclk = ~aclk;

  pfc_top #(.LOCK_PERIODS(2)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .reference_input(ref_in), .clock_source_strap(strap), .sys_clk(sys_clk),
    .sys_reset_n(sys_reset_n), .pll_lock_flag(lock), .irq(irq));

  pfc_ref_model i_ref (.aclk(aclk), .half_cycles(half), .reference_input(ref_in));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic stall(input string nm);
    errors++;
    $display("MISMATCH %s expected done seen timeout", nm);
    close_out();
  endtask : stall

  task automatic do_reset(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    wr_q.push_back(r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 64) stall("write");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rd_q.push_back({r, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 64) stall("read");
  endtask : axi_rd

  task automatic wait_lock;
    int n;
    for (n = 0; n < 40000 && lock !== 1'b1; n++) @(posedge aclk);
    if (n == 40000) stall("lock");
  endtask : wait_lock

  // System clock rising edges per reference period, averaged over three periods and rounded
  task automatic count_edges(input int exp);
    int   cnt;
    logic p;
    cnt = 0;
    p = sys_clk;
    repeat (12288) begin
      @(posedge aclk);
      if (sys_clk === 1'b1 && p === 1'b0) cnt++;
      p = sys_clk;
    end
    check("sys_clk_edges", 34'((cnt + 1) / 3), 34'(exp));
  endtask : count_edges

  // Responses compared with the oldest expectation
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready && wr_q.size() > 0) check("bresp", {32'h0, bresp}, {32'h0, wr_q.pop_front()});
    if (rvalid === 1'b1 && rready && rd_q.size() > 0) check("rdata", {rresp, rdata}, rd_q.pop_front());
  end

  initial begin
    do_reset(1'b1);
    axi_rd(pfc_pkg::ADDR_SYNTH, {16'h0, pfc_pkg::SYNTH_RESET}, pfc_pkg::RESP_OKAY);
    axi_rd(pfc_pkg::ADDR_IRQ_MASK, 32'h0, pfc_pkg::RESP_OKAY);
    check("sys_reset_n", {33'h0, sys_reset_n}, 34'h0);
    rnd = lfsr(rnd);
    axi_wr(pfc_pkg::ADDR_SYNTH, {rnd[31:16], 8'h00, rnd[7:0]}, pfc_pkg::RESP_OKAY);
    axi_rd(pfc_pkg::ADDR_SYNTH, 32'h0, pfc_pkg::RESP_OKAY);
    $display("test reset_value done");
    wait_lock();
    repeat (3) @(posedge aclk);
    check("sys_reset_n", {33'h0, sys_reset_n}, 34'h1);
    axi_rd(pfc_pkg::ADDR_SYNTH, 32'h8, pfc_pkg::RESP_OKAY);
    count_edges(4);
    axi_wr(pfc_pkg::ADDR_SYNTH, 32'h4000, pfc_pkg::RESP_OKAY);
    axi_rd(pfc_pkg::ADDR_SYNTH, 32'h4008, pfc_pkg::RESP_OKAY);
    count_edges(8);
    $display("test frequency done");
    axi_wr(pfc_pkg::ADDR_REF_CTRL, 32'h1, pfc_pkg::RESP_OKAY);
    half <= 12'h010;
    repeat (8192) @(posedge aclk);
    wait_lock();
    count_edges(8);
    $display("test prediv done");
    axi_wr(pfc_pkg::ADDR_IRQ_STATUS, 32'h3, pfc_pkg::RESP_OKAY);
    axi_wr(pfc_pkg::ADDR_SYNTH, 32'hC100, pfc_pkg::RESP_OKAY);
    axi_rd(pfc_pkg::ADDR_SYNTH, 32'hC100, pfc_pkg::RESP_OKAY);
    axi_rd(pfc_pkg::ADDR_IRQ_STATUS, 32'h2, pfc_pkg::RESP_OKAY);
    check("irq", {33'h0, irq}, 34'h0);
    axi_wr(pfc_pkg::ADDR_IRQ_MASK, 32'h3, pfc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq", {33'h0, irq}, 34'h1);
    axi_wr(pfc_pkg::ADDR_IRQ_STATUS, 32'h2, pfc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq", {33'h0, irq}, 34'h0);
    rnd = lfsr(rnd);
    axi_wr(8'h10, rnd, pfc_pkg::RESP_SLVERR);
    axi_rd(8'h10, 32'h0, pfc_pkg::RESP_SLVERR);
    $display("test irq_unmapped done");
    half <= 12'h800;
    do_reset(1'b0);
    repeat (3) @(posedge aclk);
    check("sys_reset_n", {33'h0, sys_reset_n}, 34'h1);
    axi_wr(pfc_pkg::ADDR_SYNTH, 32'hC000, pfc_pkg::RESP_OKAY);
    count_edges(1);
    $display("test bypass done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
